/* File: dsss_pkg.sv */
// constants and types for the drive safety stop sequencer
//
// Contract
// - Under safe stop ramp, ramp or quick stop keeps quick-ramp braking to standstill.
// - Under safe stop ramp, coast stop engages safe torque-off at once.
// - Under limited speed, ramp or quick stop ends in safe torque-off at standstill.
// - Under limited speed, coast stop engages safe torque-off at once.
// - Under limited speed, braking uses command's ramp while speed limit stays checked.
// - No run within 5 s of torque-off release returns to torque-off, ignoring run.
// - Under speed monitor, ramp or quick stop brakes and switches off at standstill.
// - Speed feedback stays active: switch-off engages safe torque-off at standstill.
// - Speed feedback goes inactive: switch-off removes torque only non-safely.
// - Under speed monitor, coast stop switches off at once; safe only if stays-active.
// - Speed above threshold at switch-off freezes speed monitor state at 0.
// - Speed feedback goes inactive: off suspends monitoring, state 0, resumes on run.
// - Speed feedback stays active: off suspends monitoring under torque-off, windowed restart.
// - Direction stays active: stop ends in torque-off, direction flag stays 1 off.
// - Direction goes inactive: switch-off removes torque non-safely, flag goes 0.
// - Under direction monitor, coast stop switches off; safe only if stays-active.
// - Under direction monitor, braking uses command's ramp while direction stays checked.
// - Direction goes inactive: off suspends monitoring, flag 0, resumes on run.
// - Direction stays active: off suspends monitoring under torque-off, windowed restart.

// ***************************************************************
// package
// ***************************************************************
package dsss_pkg;

	// clock and switch-on window timing
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned SWON_WIN_S = 5;
	localparam int unsigned SWON_WIN_CYC = SWON_WIN_S * CLK_HZ;
	localparam int unsigned WIN_CNT_W = 28;

	// register map
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;

	// control register fields
	localparam int unsigned CTRL_SPD_STAYS_BIT = 0;
	localparam int unsigned CTRL_DIR_STAYS_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// status register fields
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_SEEN_BIT = 3;
	localparam int unsigned STAT_SPD_BIT = 4;
	localparam int unsigned STAT_DIR_BIT = 5;
	localparam int unsigned STAT_FAULT_BIT = 6;

	// sequencer states
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_RUN = 3'h1,
		ST_BRAKE = 3'h2,
		ST_TQOFF = 3'h3,
		ST_WIN = 3'h4
	} dsss_state_e;

endpackage : dsss_pkg

/* File: dsss_top.sv */
// stop-command sequencer for a drive with safety functions active
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

module dsss_top #(
	parameter int unsigned WIN_CYCLES = dsss_pkg::SWON_WIN_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic RUN_COMMAND,
	input wire logic RAMP_STOP_COMMAND,
	input wire logic COAST_STOP_COMMAND,
	input wire logic QUICK_STOP_COMMAND,
	input wire logic SEL_SAFE_TORQUE_OFF,
	input wire logic SEL_SAFE_STOP_RAMP,
	input wire logic SEL_LIMITED_SPEED_MONITOR,
	input wire logic SEL_DIRECTION_MONITOR,
	input wire logic SPEED_THRESHOLD_MONITOR_EN,
	input wire logic STANDSTILL,
	input wire logic SPEED_OVER_LIMIT,
	input wire logic SPEED_OVER_THRESHOLD,
	input wire logic DIRECTION_WRONG,
	input wire logic [dsss_pkg::ADDR_W-1:0] ADDR,
	input wire logic [dsss_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [dsss_pkg::DATA_W-1:0] RDATA,
	output logic MOTOR_ON,
	output logic BRAKING,
	output logic RAMP_QUICK,
	output logic SAFE_TORQUE_OFF,
	output logic PULSE_INHIBIT,
	output logic SPEED_MONITOR_STATE,
	output logic SPEED_MONITOR_ACTIVE_FLAG,
	output logic DIRECTION_ACTIVE_FLAG,
	output logic MONITOR_FAULT
);

	// ***************************************************************
	// parameter check
	// ***************************************************************
	// counter width bounds the window; zero would never open it
	// refused at elaboration, before any logic is built around it
	if (WIN_CYCLES < 1 || WIN_CYCLES >= (64'h1 << dsss_pkg::WIN_CNT_W)) begin : g_win_chk
		$error("WIN_CYCLES out of range");
	end

	localparam logic [dsss_pkg::WIN_CNT_W-1:0] WIN_LAST = dsss_pkg::WIN_CNT_W'(WIN_CYCLES - 1);

	// ***************************************************************
	// declarations
	// ***************************************************************
	dsss_pkg::dsss_state_e state_ff;
	dsss_pkg::dsss_state_e nxt_state;
	logic [1:0] ctrl_ff;
	logic run_q_ff;
	logic seen_ff;
	logic [dsss_pkg::WIN_CNT_W-1:0] win_cnt_ff;
	logic nxt_quick;
	logic nxt_spd;
	logic nxt_spd_act;
	logic nxt_dir;
	logic nxt_fault;
	logic run_rise;
	logic spd_stays;
	logic dir_stays;
	logic safe_off;
	logic cur_on;
	logic nxt_on;
	logic stop_any;
	logic win_done;
	logic [dsss_pkg::DATA_W-1:0] stat_word;

	assign spd_stays = ctrl_ff[dsss_pkg::CTRL_SPD_STAYS_BIT];
	assign dir_stays = ctrl_ff[dsss_pkg::CTRL_DIR_STAYS_BIT];
	assign run_rise = RUN_COMMAND & ~run_q_ff;
	assign stop_any = RAMP_STOP_COMMAND | QUICK_STOP_COMMAND | COAST_STOP_COMMAND;
	assign cur_on = (state_ff == dsss_pkg::ST_RUN) || (state_ff == dsss_pkg::ST_BRAKE);
	assign nxt_on = (nxt_state == dsss_pkg::ST_RUN) || (nxt_state == dsss_pkg::ST_BRAKE);
	assign win_done = (win_cnt_ff == WIN_LAST);

	// switch-off goes safe whenever an active function demands it
	assign safe_off = SEL_SAFE_STOP_RAMP | SEL_LIMITED_SPEED_MONITOR |
		(SPEED_THRESHOLD_MONITOR_EN & spd_stays) |
		(SEL_DIRECTION_MONITOR & dir_stays);

	// ***************************************************************
	// register port
	// ***************************************************************
	// control word: feedback behaviour of the two monitors
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl_ff <= dsss_pkg::CTRL_RST;
		end else if (WR && ADDR == dsss_pkg::CTRL_OFS) begin
			ctrl_ff <= WDATA[1:0];
		end
	end

	always_comb begin
		stat_word = '0;
		stat_word[dsss_pkg::STAT_STATE_LSB +: 3] = state_ff;
		stat_word[dsss_pkg::STAT_SEEN_BIT] = seen_ff;
		stat_word[dsss_pkg::STAT_SPD_BIT] = SPEED_MONITOR_STATE;
		stat_word[dsss_pkg::STAT_DIR_BIT] = DIRECTION_ACTIVE_FLAG;
		stat_word[dsss_pkg::STAT_FAULT_BIT] = MONITOR_FAULT;
	end

	// read data stand one cycle only; unmapped reads give zero
	always_ff @(posedge CLK) begin
		if (RST) begin
			RDATA <= '0;
		end else if (RD && ADDR == dsss_pkg::CTRL_OFS) begin
			RDATA <= {6'h00, ctrl_ff};
		end else if (RD && ADDR == dsss_pkg::STAT_OFS) begin
			RDATA <= stat_word;
		end else begin
			RDATA <= '0;
		end
	end

	// ***************************************************************
	// sequencer
	// ***************************************************************
	// run edge: a level left high never counts as a fresh switch-on
	always_ff @(posedge CLK) begin
		if (RST) begin
			run_q_ff <= 1'b1;
		end else begin
			run_q_ff <= RUN_COMMAND;
		end
	end

	// torque-off must be seen selected before its release opens the window
	always_ff @(posedge CLK) begin
		if (RST) begin
			seen_ff <= 1'b0;
		end else if (state_ff == dsss_pkg::ST_TQOFF) begin
			seen_ff <= seen_ff | SEL_SAFE_TORQUE_OFF;
		end else begin
			seen_ff <= 1'b0;
		end
	end

	// switch-on window counter, runs only while the window is open
	always_ff @(posedge CLK) begin
		if (RST) begin
			win_cnt_ff <= '0;
		end else if (state_ff == dsss_pkg::ST_WIN && !win_done) begin
			win_cnt_ff <= win_cnt_ff + 1'b1;
		end else begin
			win_cnt_ff <= '0;
		end
	end

	// next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			dsss_pkg::ST_OFF: begin
				if (SEL_SAFE_TORQUE_OFF) begin
					nxt_state = dsss_pkg::ST_TQOFF;
				end else if (run_rise && !stop_any && !SEL_SAFE_STOP_RAMP) begin
					nxt_state = dsss_pkg::ST_RUN;
				end
			end
			dsss_pkg::ST_RUN: begin
				if (SEL_SAFE_TORQUE_OFF) begin
					nxt_state = dsss_pkg::ST_TQOFF;
				end else if (COAST_STOP_COMMAND) begin
					nxt_state = safe_off ? dsss_pkg::ST_TQOFF : dsss_pkg::ST_OFF;
				end else if (SEL_SAFE_STOP_RAMP || RAMP_STOP_COMMAND || QUICK_STOP_COMMAND || !RUN_COMMAND) begin
					nxt_state = dsss_pkg::ST_BRAKE;
				end
			end
			dsss_pkg::ST_BRAKE: begin
				// a stop already under way finishes; only coast or a torque-off select cuts it short
				if (SEL_SAFE_TORQUE_OFF) begin
					nxt_state = dsss_pkg::ST_TQOFF;
				end else if (COAST_STOP_COMMAND) begin
					nxt_state = safe_off ? dsss_pkg::ST_TQOFF : dsss_pkg::ST_OFF;
				end else if (STANDSTILL) begin
					nxt_state = safe_off ? dsss_pkg::ST_TQOFF : dsss_pkg::ST_OFF;
				end
			end
			dsss_pkg::ST_TQOFF: begin
				// run is ignored here; leave by select-release or full deselect
				if (seen_ff && !SEL_SAFE_TORQUE_OFF) begin
					nxt_state = dsss_pkg::ST_WIN;
				end else if (!SEL_SAFE_TORQUE_OFF && !SEL_SAFE_STOP_RAMP && !SEL_LIMITED_SPEED_MONITOR &&
					!SEL_DIRECTION_MONITOR && !SPEED_THRESHOLD_MONITOR_EN && !stop_any && !RUN_COMMAND) begin
					nxt_state = dsss_pkg::ST_OFF;
				end
			end
			dsss_pkg::ST_WIN: begin
				if (SEL_SAFE_TORQUE_OFF) begin
					nxt_state = dsss_pkg::ST_TQOFF;
				end else if (run_rise && !stop_any) begin
					nxt_state = dsss_pkg::ST_RUN;
				end else if (win_done) begin
					nxt_state = dsss_pkg::ST_TQOFF;
				end
			end
			default: begin
				nxt_state = dsss_pkg::ST_TQOFF;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_ff <= dsss_pkg::ST_TQOFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	// ramp choice is latched on entry; safe stop ramp forces quick ramp
	always_comb begin
		nxt_quick = 1'b0;
		if (nxt_state == dsss_pkg::ST_BRAKE) begin
			if (state_ff == dsss_pkg::ST_BRAKE)
				nxt_quick = RAMP_QUICK | SEL_SAFE_STOP_RAMP;
			else
				nxt_quick = QUICK_STOP_COMMAND | SEL_SAFE_STOP_RAMP;
		end
	end

	// speed monitor status: live while on, frozen or cleared while off
	always_comb begin
		if (nxt_on) begin
			nxt_spd = SPEED_THRESHOLD_MONITOR_EN & ~SPEED_OVER_THRESHOLD;
		end else if (!spd_stays) begin
			nxt_spd = 1'b0;
		end else if (cur_on) begin
			nxt_spd = SPEED_THRESHOLD_MONITOR_EN & ~SPEED_OVER_THRESHOLD;
		end else begin
			nxt_spd = SPEED_MONITOR_STATE;
		end
		nxt_spd_act = SPEED_THRESHOLD_MONITOR_EN & (nxt_on | spd_stays);
	end

	// direction flag: held at 1 off only with stays-active feedback
	always_comb begin
		if (nxt_on) begin
			nxt_dir = SEL_DIRECTION_MONITOR;
		end else if (!dir_stays) begin
			nxt_dir = 1'b0;
		end else if (cur_on) begin
			nxt_dir = SEL_DIRECTION_MONITOR;
		end else begin
			nxt_dir = DIRECTION_ACTIVE_FLAG & SEL_DIRECTION_MONITOR;
		end
	end

	// limit and direction keep being checked while braking
	assign nxt_fault = nxt_on & ((SEL_LIMITED_SPEED_MONITOR & SPEED_OVER_LIMIT) |
		(SEL_DIRECTION_MONITOR & DIRECTION_WRONG));

	always_ff @(posedge CLK) begin
		if (RST) begin
			MOTOR_ON <= 1'b0;
			BRAKING <= 1'b0;
			RAMP_QUICK <= 1'b0;
			SAFE_TORQUE_OFF <= 1'b1;
			PULSE_INHIBIT <= 1'b0;
		end else begin
			MOTOR_ON <= nxt_on;
			BRAKING <= nxt_state == dsss_pkg::ST_BRAKE;
			RAMP_QUICK <= nxt_quick;
			SAFE_TORQUE_OFF <= nxt_state == dsss_pkg::ST_TQOFF;
			PULSE_INHIBIT <= nxt_state == dsss_pkg::ST_OFF || nxt_state == dsss_pkg::ST_WIN;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			SPEED_MONITOR_STATE <= 1'b0;
			SPEED_MONITOR_ACTIVE_FLAG <= 1'b0;
			DIRECTION_ACTIVE_FLAG <= 1'b0;
			MONITOR_FAULT <= 1'b0;
		end else begin
			SPEED_MONITOR_STATE <= nxt_spd;
			SPEED_MONITOR_ACTIVE_FLAG <= nxt_spd_act;
			DIRECTION_ACTIVE_FLAG <= nxt_dir;
			MONITOR_FAULT <= nxt_fault;
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// coast under ramp function engages torque-off next edge
	ramp_coast_a: assert property (
		(state_ff == dsss_pkg::ST_BRAKE || state_ff == dsss_pkg::ST_RUN) && SEL_SAFE_STOP_RAMP &&
		COAST_STOP_COMMAND |=> SAFE_TORQUE_OFF && !MOTOR_ON)
		else $error("coast under ramp function missed torque-off");

	limit_coast_a: assert property (
		MOTOR_ON && SEL_LIMITED_SPEED_MONITOR && COAST_STOP_COMMAND |=> SAFE_TORQUE_OFF)
		else $error("coast under limited speed missed torque-off");

	// any braking cycle decided with the ramp function selected is on quick ramp
	quick_ramp_a: assert property (
		SEL_SAFE_STOP_RAMP |=> !BRAKING || RAMP_QUICK)
		else $error("ramp function braking not on quick ramp");

	limit_standstill_a: assert property (
		state_ff == dsss_pkg::ST_BRAKE && SEL_LIMITED_SPEED_MONITOR && STANDSTILL &&
		!COAST_STOP_COMMAND |=> SAFE_TORQUE_OFF ##1 !MOTOR_ON)
		else $error("limited speed standstill did not reach torque-off");

	win_expire_a: assert property (
		state_ff == dsss_pkg::ST_WIN && win_done && !run_rise && !SEL_SAFE_TORQUE_OFF |=>
		SAFE_TORQUE_OFF && state_ff == dsss_pkg::ST_TQOFF)
		else $error("switch-on window expiry did not return to torque-off");

	tqoff_ignores_run_a: assert property (
		state_ff == dsss_pkg::ST_TQOFF |=> !MOTOR_ON)
		else $error("run accepted in torque-off state");

	spd_freeze_a: assert property (
		$fell(MOTOR_ON) && $past(SPEED_OVER_THRESHOLD) |-> !SPEED_MONITOR_STATE)
		else $error("speed monitor state not frozen at 0");

	spd_inactive_a: assert property (
		!MOTOR_ON && !$past(spd_stays) |-> !SPEED_MONITOR_STATE)
		else $error("speed monitor state not 0 while off");

	dir_stays_a: assert property (
		$fell(MOTOR_ON) && $past(SEL_DIRECTION_MONITOR) && $past(dir_stays) |-> DIRECTION_ACTIVE_FLAG)
		else $error("direction flag dropped while off");

	dir_inactive_a: assert property (
		!MOTOR_ON && !$past(dir_stays) |-> !DIRECTION_ACTIVE_FLAG)
		else $error("direction flag not 0 while off");

	// main scenarios
	win_restart_c: cover property (state_ff == dsss_pkg::ST_WIN ##1 MOTOR_ON);
	win_timeout_c: cover property (state_ff == dsss_pkg::ST_WIN && win_done ##1 state_ff == dsss_pkg::ST_TQOFF);
	plain_off_c: cover property ($fell(MOTOR_ON) && PULSE_INHIBIT);
	fault_c: cover property (BRAKING && MONITOR_FAULT);

endmodule : dsss_top

/* File: dsss_ctrl_model.sv */
// machine controller model driving selections and stop commands
`timescale 1ns/1ps

// ****************************************
// controller model
// ****************************************
module dsss_ctrl_model (
	input wire logic clk,
	output logic [8:0] cmd
);
	logic [8:0] cmd_ff = 9'h000;

	// levels held between changes, so the sequencer sees clean steps
	assign cmd = cmd_ff;

	// masked level change just after the next edge
	task put(input logic [8:0] m, input logic [8:0] v);
		@(posedge clk);
		cmd_ff <= (cmd_ff & ~m) | (v & m);
	endtask : put

	// functions off first, then stops, then run off and on again
	task restart(input logic [8:0] keep, input int gap);
		put(9'h01f & ~keep, 9'h000);
		repeat (gap) @(posedge clk);
		put(9'h0e0 & ~keep, 9'h000);
		put(9'h100, 9'h000);
		repeat (gap) @(posedge clk);
		put(9'h100, 9'h100);
	endtask : restart

	// select then release torque-off; a slow hold is as legal as a short one
	task sto_pulse(input int hold);
		put(9'h010, 9'h010);
		repeat (hold) @(posedge clk);
		put(9'h010, 9'h000);
	endtask : sto_pulse
endmodule : dsss_ctrl_model

/* File: test_drive_safety_stop_sequencer.sv */
// self-checking bench for the drive safety stop sequencer
`timescale 1ns/1ps

// ****************************************
// bench
// ****************************************
module test_drive_safety_stop_sequencer;
	localparam int unsigned WIN = 20;
	localparam logic [8:0] B_RUN = 9'h100, B_RMP = 9'h080, B_CST = 9'h040, B_QCK = 9'h020;
	localparam logic [8:0] B_SS1 = 9'h008, B_LSM = 9'h004, B_DIR = 9'h002, B_SSM = 9'h001;
	localparam logic [7:0] O_ON = 8'h80, O_BRK = 8'h40, O_QK = 8'h20, O_STO = 8'h10;
	localparam logic [7:0] O_PI = 8'h08, O_SMS = 8'h04, O_SMA = 8'h02, O_DIR = 8'h01;
	logic CLK, RST, STANDSTILL, SPEED_OVER_LIMIT, SPEED_OVER_THRESHOLD, DIRECTION_WRONG, WR, RD;
	logic RUN_COMMAND, RAMP_STOP_COMMAND, COAST_STOP_COMMAND, QUICK_STOP_COMMAND, SEL_SAFE_TORQUE_OFF;
	logic SEL_SAFE_STOP_RAMP, SEL_LIMITED_SPEED_MONITOR, SEL_DIRECTION_MONITOR, SPEED_THRESHOLD_MONITOR_EN;
	logic MOTOR_ON, BRAKING, RAMP_QUICK, SAFE_TORQUE_OFF, PULSE_INHIBIT, MONITOR_FAULT;
	logic SPEED_MONITOR_STATE, SPEED_MONITOR_ACTIVE_FLAG, DIRECTION_ACTIVE_FLAG;
	logic [dsss_pkg::ADDR_W-1:0] ADDR;
	logic [dsss_pkg::DATA_W-1:0] WDATA, RDATA, rd_v;
	logic [8:0] cmd;
	int fail_count = 0, tests_run = 0, seed = 32'h1d0f, gap, i;

	// controller levels fan out to the command pins
	dsss_ctrl_model ctrl_u (.clk(CLK), .cmd(cmd));
	assign {RUN_COMMAND, RAMP_STOP_COMMAND, COAST_STOP_COMMAND, QUICK_STOP_COMMAND, SEL_SAFE_TORQUE_OFF,
		SEL_SAFE_STOP_RAMP, SEL_LIMITED_SPEED_MONITOR, SEL_DIRECTION_MONITOR, SPEED_THRESHOLD_MONITOR_EN} = cmd;
	dsss_top #(.WIN_CYCLES(WIN)) dut_u (.CLK, .RST, .RUN_COMMAND, .RAMP_STOP_COMMAND, .COAST_STOP_COMMAND,
		.QUICK_STOP_COMMAND, .SEL_SAFE_TORQUE_OFF, .SEL_SAFE_STOP_RAMP, .SEL_LIMITED_SPEED_MONITOR,
		.SEL_DIRECTION_MONITOR, .SPEED_THRESHOLD_MONITOR_EN, .STANDSTILL, .SPEED_OVER_LIMIT,
		.SPEED_OVER_THRESHOLD, .DIRECTION_WRONG, .ADDR, .WDATA, .WR, .RD, .RDATA, .MOTOR_ON, .BRAKING,
		.RAMP_QUICK, .SAFE_TORQUE_OFF, .PULSE_INHIBIT, .SPEED_MONITOR_STATE, .SPEED_MONITOR_ACTIVE_FLAG,
		.DIRECTION_ACTIVE_FLAG, .MONITOR_FAULT);

	// 50 MHz clock
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	// status outputs packed for masked comparison
	function automatic logic [7:0] outs();
		return {MOTOR_ON, BRAKING, RAMP_QUICK, SAFE_TORQUE_OFF, PULSE_INHIBIT, SPEED_MONITOR_STATE,
			SPEED_MONITOR_ACTIVE_FLAG, DIRECTION_ACTIVE_FLAG};
	endfunction : outs

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task co(input logic [7:0] m, input logic [7:0] e);
		chk(outs() & m, e);
	endtask : co

	// settle 1 ns past the edge so that edge's updates have landed
	task tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : tick

	// sensor levels: standstill, over limit, over threshold, wrong direction
	task sn(input logic [3:0] v);
		@(posedge CLK);
		{STANDSTILL, SPEED_OVER_LIMIT, SPEED_OVER_THRESHOLD, DIRECTION_WRONG} <= v;
	endtask : sn

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task rd(input logic [3:0] a);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1;
		rd_v = RDATA;
	endtask : rd

	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	// rule model of the sequencer state, held against the pins at every edge
	int m_st = 3, m_nx = 3, m_cnt = 0;
	logic [1:0] m_ctrl = 2'h0;
	logic [7:0] m_exp;
	logic m_seen = 1'b0, m_rq = 1'b1, m_sf, m_stp, m_sel, m_rise;
	always @(posedge CLK) begin
		if (RST) begin
			m_st = 3;
			m_cnt = 0;
			m_ctrl = 2'h0;
			m_seen = 1'b0;
			m_rq = 1'b1;
		end else begin
			m_exp = {4'h0, m_st == 1 || m_st == 2, m_st == 2, m_st == 3, m_st == 0 || m_st == 4};
			chk({4'h0, MOTOR_ON, BRAKING, SAFE_TORQUE_OFF, PULSE_INHIBIT}, m_exp);
			m_sel = SEL_SAFE_STOP_RAMP | SEL_LIMITED_SPEED_MONITOR |
				SEL_DIRECTION_MONITOR | SPEED_THRESHOLD_MONITOR_EN;
			m_sf = SEL_SAFE_STOP_RAMP | SEL_LIMITED_SPEED_MONITOR | (SPEED_THRESHOLD_MONITOR_EN & m_ctrl[0]) |
				(SEL_DIRECTION_MONITOR & m_ctrl[1]);
			m_stp = RAMP_STOP_COMMAND | COAST_STOP_COMMAND | QUICK_STOP_COMMAND;
			m_rise = RUN_COMMAND & ~m_rq;
			m_nx = m_st;
			if (SEL_SAFE_TORQUE_OFF && m_st != 3)
				m_nx = 3;
			else if (m_st == 0 && m_rise && !m_stp && !SEL_SAFE_STOP_RAMP)
				m_nx = 1;
			else if ((m_st == 1 || m_st == 2) && COAST_STOP_COMMAND)
				m_nx = m_sf ? 3 : 0;
			else if (m_st == 1 && (SEL_SAFE_STOP_RAMP || RAMP_STOP_COMMAND || QUICK_STOP_COMMAND || !RUN_COMMAND))
				m_nx = 2;
			else if (m_st == 2 && STANDSTILL)
				m_nx = m_sf ? 3 : 0;
			else if (m_st == 3 && m_seen && !SEL_SAFE_TORQUE_OFF)
				m_nx = 4;
			else if (m_st == 3 && !SEL_SAFE_TORQUE_OFF && !m_sel && !m_stp && !RUN_COMMAND)
				m_nx = 0;
			else if (m_st == 4 && m_rise && !m_stp)
				m_nx = 1;
			else if (m_st == 4 && m_cnt == WIN - 1)
				m_nx = 3;
			// window length counted in whole cycles spent open
			if (m_st == 4)
				m_cnt = m_cnt + 1;
			else
				m_cnt = 0;
			m_seen = (m_st == 3) ? (m_seen | SEL_SAFE_TORQUE_OFF) : 1'b0;
			m_rq = RUN_COMMAND;
			if (WR && ADDR == dsss_pkg::CTRL_OFS)
				m_ctrl = WDATA[1:0];
			m_st = m_nx;
		end
	end

	// hang guard
	initial begin
		#1000000;
		fail_count++;
		summarize();
	end

	// reset, register checks, then each safety function in turn
	initial begin
		RST = 1'b1;
		{WR, RD, ADDR, WDATA, STANDSTILL, SPEED_OVER_LIMIT, SPEED_OVER_THRESHOLD, DIRECTION_WRONG} = '0;
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		tick(0);
		co(8'hff, O_STO);
		tick(1);
		rd(dsss_pkg::STAT_OFS);
		chk(rd_v & 8'h07, {5'h0, dsss_pkg::ST_OFF});
		gap = $random(seed);
		wr({2'b10, gap[1:0]}, gap[15:8]);
		rd({2'b10, gap[1:0]});
		chk(rd_v, 8'h00);
		rd(dsss_pkg::CTRL_OFS);
		chk(rd_v, {6'h0, dsss_pkg::CTRL_RST});
		// safe stop ramp: stops keep quick braking, coast is torque-off at once
		ctrl_u.restart(9'h000, 0);
		tick(1);
		co(O_ON | O_STO, O_ON);
		ctrl_u.put(B_SS1, B_SS1);
		ctrl_u.put(B_RMP | B_QCK, B_RMP | B_QCK);
		tick(2);
		co(O_ON | O_BRK | O_QK | O_STO, O_ON | O_BRK | O_QK);
		sn(4'h8);
		tick(1);
		co(O_ON | O_BRK | O_STO, O_STO);
		sn(4'h0);
		ctrl_u.restart(9'h000, 2);
		tick(1);
		co(O_ON, O_ON);
		ctrl_u.put(B_SS1, B_SS1);
		ctrl_u.put(B_CST, B_CST);
		tick(1);
		co(O_ON | O_BRK | O_STO, O_STO);
		// limited speed: own ramp, speed watched, torque-off at standstill, timed re-enable
		ctrl_u.restart(9'h000, 1);
		ctrl_u.put(B_LSM | B_RMP, B_LSM | B_RMP);
		tick(1);
		co(O_ON | O_BRK | O_QK, O_ON | O_BRK);
		sn(4'h4);
		tick(1);
		chk({7'h0, MONITOR_FAULT}, 8'h01);
		sn(4'h0);
		tick($unsigned($random(seed)) % 4);
		sn(4'h8);
		tick(1);
		co(O_ON | O_BRK | O_STO, O_STO);
		sn(4'h0);
		ctrl_u.put(B_RUN | B_RMP, 9'h000);
		ctrl_u.sto_pulse(2);
		tick(1);
		co(O_STO | O_PI, O_PI);
		tick(WIN - 3);
		co(O_STO | O_PI, O_PI);
		for (i = 0; i < 8 && SAFE_TORQUE_OFF !== 1'b1; i++) tick(1);
		if (i == 8) begin
			fail_count++;
			summarize();
		end
		co(O_STO | O_PI, O_STO);
		ctrl_u.put(B_RUN, B_RUN);
		tick(2);
		co(O_ON | O_STO, O_STO);
		ctrl_u.put(B_RUN, 9'h000);
		ctrl_u.sto_pulse(1);
		tick($unsigned($random(seed)) % (WIN / 2));
		ctrl_u.put(B_RUN, B_RUN);
		tick(1);
		co(O_ON | O_PI | O_STO, O_ON);
		ctrl_u.put(B_CST, B_CST);
		tick(1);
		co(O_ON | O_STO, O_STO);
		// speed monitor, feedback goes inactive: plain off, monitoring resumes on run
		ctrl_u.restart(9'h000, 0);
		gap = $random(seed);
		wr(dsss_pkg::CTRL_OFS, {gap[7:2], 2'b00});
		ctrl_u.put(B_SSM, B_SSM);
		tick(1);
		co(O_SMS | O_SMA, O_SMS | O_SMA);
		ctrl_u.put(B_RMP, B_RMP);
		tick(1);
		co(O_ON | O_BRK, O_ON | O_BRK);
		sn(4'h8);
		tick(1);
		co(O_ON | O_STO | O_PI | O_SMS | O_SMA, O_PI);
		sn(4'h0);
		ctrl_u.restart(B_SSM, 1);
		tick(1);
		co(O_ON | O_SMS | O_SMA, O_ON | O_SMS | O_SMA);
		// feedback stays active: torque-off at standstill, state frozen by overspeed
		wr(dsss_pkg::CTRL_OFS, 8'h01);
		rd(dsss_pkg::CTRL_OFS);
		chk(rd_v, 8'h01);
		ctrl_u.put(B_QCK, B_QCK);
		tick(1);
		co(O_BRK | O_QK, O_BRK | O_QK);
		sn(4'h8);
		tick(1);
		co(O_ON | O_STO | O_PI | O_SMA, O_STO | O_SMA);
		sn(4'h0);
		ctrl_u.restart(9'h000, 0);
		ctrl_u.put(B_SSM, B_SSM);
		sn(4'h2);
		ctrl_u.put(B_CST, B_CST);
		sn(4'h0);
		tick(2);
		co(O_ON | O_STO | O_SMS, O_STO);
		// direction monitor, goes inactive then stays active
		ctrl_u.restart(9'h000, 0);
		wr(dsss_pkg::CTRL_OFS, 8'h00);
		ctrl_u.put(B_DIR | B_RMP, B_DIR | B_RMP);
		sn(4'h1);
		tick(1);
		co(O_ON | O_BRK | O_QK | O_DIR, O_ON | O_BRK | O_DIR);
		chk({7'h0, MONITOR_FAULT}, 8'h01);
		sn(4'h8);
		tick(1);
		co(O_ON | O_STO | O_PI | O_DIR, O_PI);
		sn(4'h0);
		ctrl_u.restart(B_DIR, 0);
		tick(1);
		co(O_ON | O_DIR, O_ON | O_DIR);
		ctrl_u.put(B_CST, B_CST);
		tick(1);
		co(O_ON | O_STO | O_PI, O_PI);
		ctrl_u.restart(B_DIR, 0);
		wr(dsss_pkg::CTRL_OFS, 8'h02);
		ctrl_u.put(B_QCK, B_QCK);
		tick(1);
		co(O_BRK | O_QK, O_BRK | O_QK);
		sn(4'h8);
		tick(1);
		co(O_ON | O_STO | O_DIR, O_STO | O_DIR);
		sn(4'h0);
		ctrl_u.restart(9'h000, 0);
		tick(1);
		co(O_ON, O_ON);
		summarize();
	end
endmodule : test_drive_safety_stop_sequencer
